/* inc/ccc_pkg.sv */
package ccc_pkg;
	localparam logic [3:0]  ADDR_MAIN_CFG  = 4'h0;
	localparam logic [3:0]  ADDR_CAL_ADJ   = 4'h4;
	localparam logic [3:0]  ADDR_CAL_VAL   = 4'h5;
	localparam int          CAL_BIT        = 15;
	localparam int          PD_I_BIT       = 11;
	localparam int          PD_Q_BIT       = 10;
	localparam int          SEQ_BIT        = 14;
	localparam int          ACCESS_BIT     = 7;
	localparam int          DEGRADED_BIT   = 1;
	localparam int          ACTIVE_BIT     = 0;
	localparam logic [15:0] MAIN_CFG_RESET = 16'h0000;
	localparam logic [15:0] CAL_ADJ_RESET  = 16'h4000;
	localparam logic [15:0] CAL_ADJ_WMASK  = 16'h4080;
	localparam int          COEFF_WORDS    = 239;
	localparam logic [7:0]  COEFF_READS    = 8'd240;
	localparam logic [7:0]  FLUSH_CYC      = 8'd60;
	localparam int          FRAME_BITS     = 24;
	localparam int          HDR_BITS       = 8;
	localparam int          READ_FLAG_BIT  = 7;
	localparam int          SAMPLE_BITS    = 12;

	typedef enum logic [2:0] {
		CCC_POWERON = 3'b000,
		CCC_RUN     = 3'b001,
		CCC_FLUSH   = 3'b011,
		CCC_READY   = 3'b010,
		CCC_PAUSE   = 3'b101
	} ccc_state_type;

	typedef struct packed {
		logic                   ovr;
		logic [SAMPLE_BITS-1:0] data;
	} ccc_sample_type;
endpackage : ccc_pkg

/* design/ccc_sync.sv */
`timescale 1ns/1ns
module ccc_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	// three stages; level moves only once stages two and three agree
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s1_q  <= INIT;
			s2_q  <= INIT;
			s3_q  <= INIT;
			lvl_q <= INIT;
		end else begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end

	assign level_out = lvl_q;
endmodule : ccc_sync

/* design/ccc_top.sv */
`timescale 1ns/1ns
module ccc_top
	import ccc_pkg::*;
#(
	parameter int unsigned POWERON_SHORT_CYC = 32'd16384,
	parameter int unsigned POWERON_LONG_CYC  = 32'd65536,
	parameter int unsigned CAL_FULL_CYC      = 32'd8192,
	parameter int unsigned CAL_LIN_CYC       = 32'd4096,
	parameter int unsigned CAL_LOW_MIN       = 32'd1280,
	parameter int unsigned CAL_HIGH_MIN      = 32'd1280
) (
	input  wire logic           sys_clk_in,
	input  wire logic           rst_in,
	input  wire logic           cal_request_pin_in,
	input  wire logic           poweron_wait_select_in,
	input  wire logic           power_off_inphase_in,
	input  wire logic           power_off_quadrature_in,
	input  wire logic           control_mode_select_pin_in,
	input  wire logic           ser_clk_in,
	input  wire logic           ser_sel_n_in,
	input  wire logic           ser_data_in,
	output logic                ser_data_out,
	input  ccc_sample_type      conv_i_in,
	input  ccc_sample_type      conv_q_in,
	output ccc_sample_type      out_i_out,
	output ccc_sample_type      out_q_out,
	output logic                output_data_clock_out,
	output logic                trim_active_out,
	output logic                powered_down_out
);
	logic [7:0]    pins;
	logic          cal_pin, wait_sel, pdi_pin, pdq_pin, mode_pin, sclk, ssel_n, sdi;
	logic          extended_control_mode, cal_req, pd_i, pd_q, both_down;
	logic [15:0]   cfg_q, adj_q, sout_q;
	logic [23:0]   sin_q;
	logic [4:0]    bit_cnt_q;
	logic          sclk_prev_q, sclk_rise, wr_commit, rd_load;
	logic [3:0]    wr_addr, rd_addr;
	logic [15:0]   coeff_mem [COEFF_WORDS];
	logic [7:0]    rd_ptr_q, wr_ptr_q;
	logic [15:0]   low_cnt_q, high_cnt_q;
	logic          armed_q, cmd_fire, wait_prev_q, wait_change;
	ccc_state_type state_q;
	logic [31:0]   cnt_q, run_len_q;
	logic          degraded_q, clk_div_q, blank;

	ccc_sync #(.W(8), .INIT(8'h0a)) u_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.async_in   ({cal_request_pin_in, poweron_wait_select_in, power_off_inphase_in,
		              power_off_quadrature_in, control_mode_select_pin_in, ser_clk_in,
		              ser_sel_n_in, ser_data_in}),
		.level_out  (pins)
	);
	assign {cal_pin, wait_sel, pdi_pin, pdq_pin, mode_pin, sclk, ssel_n, sdi} = pins;

	// pin-only control when the mode pin is high, main config ignored; adjust trim select still sets run length
	assign extended_control_mode = ~mode_pin;
	assign cal_req   = cal_pin | (extended_control_mode & cfg_q[CAL_BIT]);
	assign pd_i      = pdi_pin | (extended_control_mode & cfg_q[PD_I_BIT]);
	assign pd_q      = pdq_pin | (extended_control_mode & cfg_q[PD_Q_BIT]);
	assign both_down = pd_i & pd_q;

	// register read view; status bits share the adjust word
	function automatic logic [15:0] reg_view(input logic [3:0] a);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			ADDR_MAIN_CFG: v = cfg_q;
			ADDR_CAL_ADJ: begin
				v = adj_q;
				v[DEGRADED_BIT] = degraded_q;
				v[ACTIVE_BIT]   = trim_active_out;
			end
			ADDR_CAL_VAL: v = (rd_ptr_q == 8'h00) ? 16'h0000 : coeff_mem[rd_ptr_q - 8'h01];
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : reg_view

	// serial frame: read flag and address byte, then sixteen data bits, msb first
	assign sclk_rise = sclk & ~sclk_prev_q;
	assign wr_addr   = sin_q[18:15];
	assign rd_addr   = {sin_q[2:0], sdi};
	assign wr_commit = sclk_rise && (bit_cnt_q == 5'(FRAME_BITS - 1))
	                   && !sin_q[22 - (HDR_BITS - 1 - READ_FLAG_BIT)];
	assign rd_load   = sclk_rise && (bit_cnt_q == 5'(HDR_BITS - 1)) && sin_q[6];

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q   <= 5'h00;
			sin_q       <= 24'h000000;
			sout_q      <= 16'h0000;
		end else begin
			sclk_prev_q <= sclk;
			if (ssel_n || !extended_control_mode) begin
				bit_cnt_q <= 5'h00;
			end else if (sclk_rise) begin
				sin_q     <= {sin_q[22:0], sdi};
				bit_cnt_q <= bit_cnt_q + 5'h01;
				sout_q    <= rd_load ? reg_view(rd_addr) : {sout_q[14:0], 1'b0};
			end
		end
	end
	assign ser_data_out = sout_q[15];

	// control registers; trim select resets to full sequence
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cfg_q <= MAIN_CFG_RESET;
			adj_q <= CAL_ADJ_RESET;
		end else if (wr_commit && !ssel_n && extended_control_mode) begin
			if (wr_addr == ADDR_MAIN_CFG) begin
				cfg_q <= {sin_q[14:0], sdi};
			end
			if (wr_addr == ADDR_CAL_ADJ) begin
				adj_q <= {sin_q[14:0], sdi} & CAL_ADJ_WMASK;
			end
		end
	end

	// coefficient pointers rewind whenever access is switched off
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !adj_q[ACCESS_BIT]) begin
			rd_ptr_q <= 8'h00;
			wr_ptr_q <= 8'h00;
		end else begin
			if (rd_load && !ssel_n && rd_addr == ADDR_CAL_VAL && rd_ptr_q < COEFF_READS) begin
				rd_ptr_q <= rd_ptr_q + 8'h01;
			end
			if (wr_commit && !ssel_n && wr_addr == ADDR_CAL_VAL && wr_ptr_q < COEFF_READS + 8'h01) begin
				wr_ptr_q <= wr_ptr_q + 8'h01;
			end
		end
	end

	// array written by the running calibration, else by restore writes
	always_ff @(posedge sys_clk_in) begin
		if (state_q == CCC_RUN && cnt_q < 32'(COEFF_WORDS)) begin
			coeff_mem[cnt_q[7:0]] <= {cnt_q[7:0], 7'h00, adj_q[SEQ_BIT]};
		end else if (wr_commit && !ssel_n && extended_control_mode && adj_q[ACCESS_BIT]
		             && wr_addr == ADDR_CAL_VAL && wr_ptr_q < 8'(COEFF_WORDS)) begin
			coeff_mem[wr_ptr_q] <= {sin_q[14:0], sdi};
		end
	end

	// low then high minimum widths filter noise on the request
	assign cmd_fire = armed_q && cal_req && (high_cnt_q == 16'(CAL_HIGH_MIN - 1));
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			low_cnt_q  <= 16'h0000;
			high_cnt_q <= 16'h0000;
			armed_q    <= 1'b0;
		end else if (!cal_req) begin
			high_cnt_q <= 16'h0000;
			if (low_cnt_q < 16'(CAL_LOW_MIN - 1)) begin
				low_cnt_q <= low_cnt_q + 16'h0001;
			end else begin
				armed_q <= 1'b1;
			end
		end else begin
			low_cnt_q <= 16'h0000;
			if (high_cnt_q < 16'(CAL_HIGH_MIN)) begin
				high_cnt_q <= high_cnt_q + 16'h0001;
			end
			if (cmd_fire) begin
				armed_q <= 1'b0;
			end
		end
	end

	// wait-select edges while powered are a start source too
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wait_prev_q <= 1'b0;
		end else begin
			wait_prev_q <= wait_sel;
		end
	end
	assign wait_change = (wait_sel != wait_prev_q);

	// calibration sequencer; every start path enters the same run state
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q    <= CCC_POWERON;
			cnt_q      <= 32'h0;
			run_len_q  <= 32'(CAL_FULL_CYC);
			degraded_q <= 1'b0;
		end else begin
			case (state_q)
				CCC_POWERON: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= (wait_sel ? POWERON_LONG_CYC : POWERON_SHORT_CYC) - 1) begin
						cnt_q      <= 32'h0;
						run_len_q  <= adj_q[SEQ_BIT] ? CAL_FULL_CYC : CAL_LIN_CYC;
						degraded_q <= 1'b0;
						state_q    <= cal_req ? CCC_READY : CCC_RUN;
					end
				end
				CCC_READY: begin
					cnt_q <= 32'h0;
					if (cmd_fire || wait_change) begin
						run_len_q  <= adj_q[SEQ_BIT] ? CAL_FULL_CYC : CAL_LIN_CYC;
						degraded_q <= 1'b0;
						state_q    <= CCC_RUN;
					end
				end
				CCC_RUN: begin
					if (both_down) begin
						degraded_q <= 1'b1;
						state_q    <= CCC_PAUSE;
					end else if (cnt_q >= run_len_q - 32'h1) begin
						cnt_q   <= 32'h0;
						state_q <= CCC_FLUSH;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				CCC_PAUSE: begin
					if (!both_down) begin
						state_q <= CCC_RUN;
					end
				end
				CCC_FLUSH: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q == 32'(FLUSH_CYC) - 32'h1) begin
						cnt_q   <= 32'h0;
						state_q <= CCC_READY;
					end
				end
				default: begin
					state_q <= CCC_POWERON;
					cnt_q   <= 32'h0;
				end
			endcase
		end
	end

	// paused time still counts as calibrating
	assign trim_active_out = (state_q == CCC_RUN) || (state_q == CCC_PAUSE);

	// divider never looks at the sequencer, so the clock stalls only during reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			clk_div_q <= 1'b0;
		end else begin
			clk_div_q <= ~clk_div_q;
		end
	end
	assign output_data_clock_out = clk_div_q;

	// quiet outputs cut noise into the analog during calibration and flush
	assign blank = (state_q != CCC_READY) || both_down;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			out_i_out        <= '0;
			out_q_out        <= '0;
			powered_down_out <= 1'b0;
		end else begin
			powered_down_out <= both_down;
			out_i_out        <= (blank || pd_i) ? '0 : conv_i_in;
			out_q_out        <= (blank || pd_q) ? '0 : conv_q_in;
		end
	end
endmodule : ccc_top

/* verif/ccc_checker.sv */
`timescale 1ns/1ns
module ccc_checker
	import ccc_pkg::*;
#(
	parameter int unsigned CAL_FULL_CYC = 32'd8192,
	parameter int unsigned CAL_LIN_CYC  = 32'd4096
) (
	input wire logic           sys_clk_in,
	input wire logic           rst_in,
	input wire ccc_sample_type out_i_out,
	input wire ccc_sample_type out_q_out,
	input wire logic           output_data_clock_out,
	input wire logic           trim_active_out,
	input wire logic           powered_down_out
);
	int unsigned run_q;
	logic        pause_q;
	logic [6:0]  fl_q;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// length of the current busy stretch
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !trim_active_out)
			run_q <= 0;
		else
			run_q <= run_q + 1;
	end

	// a paused run is longer, so its length is not judged
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !trim_active_out)
			pause_q <= 1'b0;
		else if (powered_down_out)
			pause_q <= 1'b1;
	end

	// cycles since busy fell, saturating
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || trim_active_out)
			fl_q <= 7'h00;
		else if (run_q != 0)
			fl_q <= 7'h01;
		else if (fl_q != 7'h00 && fl_q < 7'h3d)
			fl_q <= fl_q + 7'h01;
	end

	a_blank_run: assert property (trim_active_out && $past(trim_active_out) |->
		out_i_out == '0 && out_q_out == '0) else $error("outputs not blank while busy");
	a_clock_runs: assert property (!$past(rst_in) |->
		output_data_clock_out != $past(output_data_clock_out)) else $error("data clock stalled");
	a_flush_blank: assert property (fl_q >= 7'h01 && fl_q <= 7'h3c |->
		out_i_out == '0 && out_q_out == '0) else $error("data shown during flush");
	a_flush_quiet: assert property (fl_q >= 7'h01 && fl_q <= 7'h3b |->
		!trim_active_out) else $error("busy during flush");
	a_run_length: assert property ($fell(trim_active_out) && !pause_q |->
		run_q == CAL_FULL_CYC || run_q == CAL_LIN_CYC) else $error("bad run length");
	a_pause_holds: assert property (trim_active_out && powered_down_out |=>
		trim_active_out) else $error("busy dropped while powered down");
	a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !trim_active_out &&
		out_i_out == '0 && !powered_down_out) else $error("outputs live in reset");
	a_run_min: assert property ($rose(trim_active_out) |->
		trim_active_out [*8]) else $error("busy pulse too short");

	c_run_end: cover property ($fell(trim_active_out));
	c_paused: cover property (trim_active_out && powered_down_out);
	c_flush_end: cover property (fl_q == 7'h3c);
endmodule : ccc_checker

bind ccc_top ccc_checker #(
	.CAL_FULL_CYC(CAL_FULL_CYC),
	.CAL_LIN_CYC (CAL_LIN_CYC)
) i_chk (
	.sys_clk_in           (sys_clk_in),
	.rst_in               (rst_in),
	.out_i_out            (out_i_out),
	.out_q_out            (out_q_out),
	.output_data_clock_out(output_data_clock_out),
	.trim_active_out      (trim_active_out),
	.powered_down_out     (powered_down_out)
);

/* verif/ccc_host.sv */
`timescale 1ns/1ns
module ccc_host (
	input  wire logic sys_clk_in,
	input  wire logic ser_data_in,
	output logic      ser_clk_out,
	output logic      ser_sel_n_out,
	output logic      ser_data_out
);
	// idle: deselected, clock parked low
	initial begin
		ser_clk_out   = 1'b0;
		ser_sel_n_out = 1'b1;
		ser_data_out  = 1'b0;
	end

	// one frame msb first; 4-clock phases meet the pin filter
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [15:0] wd,
		output logic [15:0] q);
		logic [23:0] f;
		f = {rd, 3'h0, a, wd};
		q = 16'h0000;
		@(negedge sys_clk_in);
		ser_sel_n_out = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			ser_data_out = f[i];
			repeat (4) @(negedge sys_clk_in);
			// read bit has settled since the previous rise
			if (i < 16)
				q[i] = ser_data_in;
			ser_clk_out = 1'b1;
			repeat (4) @(negedge sys_clk_in);
			ser_clk_out = 1'b0;
		end
		repeat (4) @(negedge sys_clk_in);
		ser_sel_n_out = 1'b1;
		ser_data_out  = ~ser_data_out; // released line must not look held
		repeat (4) @(negedge sys_clk_in);
	endtask : xfer
endmodule : ccc_host

/* verif/testbench.sv */
`timescale 1ns/1ns
module testbench
	import ccc_pkg::*;
;
	typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] e;} ccc_row_type;
	logic           clk, rst, cal, ws, offi, offq, mode, sck, ssn, mosi, miso, odc, trim, pdn;
	ccc_sample_type ci, cq, oi, oq;
	int             fails, samples_checked, n;
	logic [15:0]    q;
	ccc_row_type    rows [5] = '{'{4'h0, 16'h1234, 16'h1234}, '{4'h3, 16'hffff, 16'h0000},
		'{4'h4, 16'hffff, 16'h4080}, '{4'h4, 16'h0000, 16'h0000}, '{4'h0, 16'h0, 16'h0}};

	ccc_top #(.POWERON_SHORT_CYC(20), .POWERON_LONG_CYC(40), .CAL_FULL_CYC(300),
		.CAL_LIN_CYC(260), .CAL_LOW_MIN(4), .CAL_HIGH_MIN(4)) i_dut (.sys_clk_in(clk),
		.rst_in(rst), .cal_request_pin_in(cal), .poweron_wait_select_in(ws),
		.power_off_inphase_in(offi), .power_off_quadrature_in(offq),
		.control_mode_select_pin_in(mode), .ser_clk_in(sck), .ser_sel_n_in(ssn),
		.ser_data_in(mosi), .ser_data_out(miso), .conv_i_in(ci), .conv_q_in(cq),
		.out_i_out(oi), .out_q_out(oq), .output_data_clock_out(odc),
		.trim_active_out(trim), .powered_down_out(pdn));
	ccc_host i_host (.sys_clk_in(clk), .ser_data_in(miso), .ser_clk_out(sck),
		.ser_sel_n_out(ssn), .ser_data_out(mosi));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(logic [3:0] a, logic [15:0] d);
		i_host.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(logic [3:0] a);
		i_host.xfer(1'b1, a, 16'h0000, q);
	endtask : rd
	// n is the number of cycles waited, capped at lim
	task automatic wait_trim(logic lvl, int lim);
		n = 0;
		while (trim !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_trim
	// request held low before, high 8 cycles, well past the minimums
	task automatic pulse();
		cal = 1'b1;
		repeat (8) @(negedge clk);
		cal = 1'b0;
	endtask : pulse
	task automatic do_reset(logic w, logic p);
		rst = 1'b1;
		ws  = w;
		cal = p;
		repeat (5) @(negedge clk);
		rst = 1'b0;
	endtask : do_reset
	// no serial traffic until the flush is over
	task automatic cal_done(int lo, int hi);
		wait_trim(1'b0, 700);
		check("run length", 16'(n >= lo && n <= hi), 16'h0001);
		repeat (57) @(negedge clk);
		check("blank i", 16'(oi), 16'h0000);
		check("blank q", 16'(oq), 16'h0000);
		// fresh samples, so stale data cannot pass
		ci = ~ci;
		cq = ~cq;
		repeat (5) @(negedge clk);
		check("data i", 16'(oi), 16'(ci));
		check("data q", 16'(oq), offq ? 16'h0000 : 16'(cq));
	endtask : cal_done
	task automatic end_sim();
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// a hang counts as a failure
	initial begin
		repeat (110000) @(posedge clk);
		fails++;
		end_sim();
	end

	initial begin
		{fails, samples_checked, q} = '0;
		{cal, ws, offi, offq, mode} = '0;
		ci = {1'b1, 12'habc};
		cq = {1'b0, 12'h123};
		do_reset(1'b0, 1'b0); // first run uses the default full sequence
		wait_trim(1'b1, 40);
		check("short delay", 16'(n >= 20 && n <= 30), 16'h0001);
		cal_done(296, 301);
		rd(4'h0);
		check("main reset", q, 16'h0000);
		rd(4'h4);
		check("adjust reset", q, 16'h4000);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a);
			check("register", q, rows[k].e);
		end
		wr(4'h4, 16'h4080);
		for (int k = 0; k < 240; k++) begin
			rd(4'h5);
			check("coeff", q, k == 0 ? 16'h0000 : 16'((k - 1) * 256 + 1));
		end
		wr(4'h4, 16'h4000);
		wr(4'h4, 16'h4080);
		for (int k = 0; k < 241; k++)
			wr(4'h5, k < 239 ? 16'(16'h5a00 + k) : 16'h0000);
		wr(4'h4, 16'h4000);
		wr(4'h4, 16'h4080);
		for (int k = 0; k < 3; k++) begin
			rd(4'h5);
			check("restored", q, k == 0 ? 16'h0000 : 16'(16'h59ff + k));
		end
		wr(4'h4, 16'h0000);
		pulse();
		wait_trim(1'b1, 20);
		check("pin start", 16'(n < 20), 16'h0001);
		cal_done(256, 261);
		wr(4'h4, 16'h4000);
		wr(4'h0, 16'h8000);
		wait_trim(1'b1, 20);
		check("bit start", 16'(n < 20), 16'h0001);
		cal_done(296, 301);
		pulse();
		wait_trim(1'b1, 30);
		check("held bit", 16'(n), 16'd30);
		wr(4'h0, 16'h0000);
		pulse();
		wait_trim(1'b1, 20);
		repeat (50) @(negedge clk);
		{offi, offq} = 2'b11;
		repeat (100) @(negedge clk);
		check("paused", {14'h0, trim, pdn}, 16'h0003);
		offi = 1'b0; // one channel back up resumes the run
		cal_done(230, 262);
		rd(4'h4);
		check("degraded", q, 16'h4002);
		wr(4'h0, 16'h0800);
		repeat (8) @(negedge clk);
		check("reg off", 16'(pdn), 16'h0001);
		mode = 1'b1;
		repeat (8) @(negedge clk);
		check("pin mode", 16'(pdn), 16'h0000);
		{mode, offq} = 2'b00;
		repeat (8) @(negedge clk);
		wr(4'h0, 16'h0c00);
		repeat (8) @(negedge clk);
		check("reg both off", 16'(pdn), 16'h0001);
		wr(4'h0, 16'h0000);
		ws = 1'b1; // wait-select edge starts a recalibration after the channel power changes
		wait_trim(1'b1, 20);
		check("select change", 16'(n < 20), 16'h0001);
		cal_done(296, 301);
		do_reset(1'b0, 1'b1); // request held high through the power-on wait
		wait_trim(1'b1, 80);
		check("skip", 16'(n), 16'd80);
		cal = 1'b0;
		repeat (8) @(negedge clk);
		pulse();
		wait_trim(1'b1, 20);
		check("late start", 16'(n < 20), 16'h0001);
		cal_done(296, 301);
		do_reset(1'b1, 1'b0);
		wait_trim(1'b1, 60);
		check("long delay", 16'(n >= 40 && n <= 50), 16'h0001);
		cal_done(296, 301);
		end_sim();
	end
endmodule : testbench
